// *** verilog/timer_cc_pkg.sv ***
// constants and carrier types for the timer capture/compare unit
package timer_cc_pkg;
    // register offsets on the byte bus
    localparam logic [7:0] ADDR_PORT_C_DIR = 8'h06;
    localparam logic [7:0] ADDR_CMP_ENABLES = 8'h0E;
    localparam logic [7:0] ADDR_CONTROL = 8'h12;
    localparam logic [7:0] ADDR_FLAGS = 8'h13;
    localparam logic [7:0] ADDR_CAPT_HIGH = 8'h14;
    localparam logic [7:0] ADDR_CAPT_LOW = 8'h15;
    localparam logic [7:0] ADDR_CMPV_HIGH = 8'h16;
    localparam logic [7:0] ADDR_CMPV_LOW = 8'h17;
    localparam logic [7:0] ADDR_PRIM_HIGH = 8'h18;
    localparam logic [7:0] ADDR_PRIM_LOW = 8'h19;
    localparam logic [7:0] ADDR_ALT_HIGH = 8'h1A;
    localparam logic [7:0] ADDR_ALT_LOW = 8'h1B;
    // field positions
    localparam int BIT_CAPT_IRQ_EN = 7;
    localparam int BIT_MATCH_IRQ_EN = 6;
    localparam int BIT_ROLL_IRQ_EN = 5;
    localparam int BIT_EDGE_POL = 1;
    localparam int BIT_CAPT_FLAG = 7;
    localparam int BIT_MATCH_FLAG = 6;
    localparam int BIT_ROLL_FLAG = 5;
    localparam int BIT_COMPARATOR_EN = 7;
    localparam int BIT_MATCH_PIN_EN = 7;
    // reset values and prescaler last count
    localparam logic [15:0] COUNT_PRESET = 16'hFFFC;
    localparam logic [7:0] PORT_C_DIR_RESET = 8'h00;
    localparam logic [7:0] CMP_ENABLES_RESET = 8'h00;
    localparam logic [1:0] PRESCALE_LAST = 2'h3;
    // timing: oscillator start-up delay and clock rate
    localparam int CLOCK_MHZ = 200;
    localparam int STARTUP_NS = 20320;
    localparam int STARTUP_CYCLES = (STARTUP_NS * CLOCK_MHZ + 999) / 1000;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
endpackage

// *** verilog/capture_sync.sv ***
// two-stage synchroniser with polarity-selected edge detector
`timescale 1ns/1ps
module capture_sync (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // asynchronous level and polarity
    input wire logic level_in,
    input wire logic rising_in,
    // synchronised level and edge pulse
    output logic level_out,
    output logic edge_out
);
    logic stage1;
    logic stage2;
    logic stage3;
    wire rise = stage2 & ~stage3;
    wire fall = ~stage2 & stage3;

    // stage3 tracks through reset, so a high pin gives no false edge on release
    always_ff @(posedge clock_in) begin
        stage1 <= level_in;
        stage2 <= stage1;
        stage3 <= stage2;
        if (reset_in) begin
            edge_out <= 1'b0;
        end else begin
            edge_out <= rising_in ? rise : fall;
        end
    end
    assign level_out = stage2;
endmodule // capture_sync

// *** verilog/timer_capture_compare_unit.sv ***
// 16-bit free-running counter with capture, compare and flag-neutral read
`timescale 1ns/1ps
module timer_capture_compare_unit
    import timer_cc_pkg::*;
#(
    parameter int STARTUP_COUNT = STARTUP_CYCLES
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // register port
    input wire bus_req_t bus_in,
    output logic [7:0] read_data_out,
    // capture pin and shared port b bit
    input wire logic capture_input_pin_in,
    input wire logic comparator_result_in,
    input wire logic port_b_bit0_data_in,
    input wire logic port_b_bit0_dir_in,
    output logic port_b_bit0_oe_out,
    output logic port_b_bit0_read_out,
    output logic comparator_power_out,
    // shared port c bit
    input wire logic port_c_bit0_data_in,
    output logic match_output_pin_out,
    output logic match_output_pin_oe_out,
    // interrupt request
    output logic timer_irq_out
);
    localparam logic [15:0] START_LAST = 16'(STARTUP_COUNT - 1);

    logic [15:0] count;
    logic [1:0] prescale;
    logic [15:0] startup;
    logic running;
    logic [7:0] alt_low_hold;
    logic alt_frozen;
    logic [7:0] prim_low_hold;
    logic prim_frozen;
    logic [7:0] port_c_dir;
    logic [7:0] cmp_enables;
    logic [2:0] irq_enables;
    logic edge_polarity = 1'b0;
    logic capture_flag = 1'b0;
    logic match_flag = 1'b0;
    logic rollover_flag = 1'b0;
    logic capture_armed;
    logic match_armed;
    logic rollover_armed;
    logic [15:0] captured = 16'h0000;
    logic capture_blocked;
    logic [15:0] compare_value = 16'h0000;
    logic compare_on;
    logic capture_edge;
    logic capture_level;

    function automatic logic hit(input bus_req_t b, input logic [7:0] a, input logic w);
        hit = (b.addr == a) & (w ? b.wr : b.rd);
    endfunction

    // access decode
    wire rd_flags = hit(bus_in, ADDR_FLAGS, 1'b0);
    wire rd_capt_high = hit(bus_in, ADDR_CAPT_HIGH, 1'b0);
    wire rd_capt_low = hit(bus_in, ADDR_CAPT_LOW, 1'b0);
    wire rd_prim_high = hit(bus_in, ADDR_PRIM_HIGH, 1'b0);
    wire rd_prim_low = hit(bus_in, ADDR_PRIM_LOW, 1'b0);
    wire rd_alt_high = hit(bus_in, ADDR_ALT_HIGH, 1'b0);
    wire rd_alt_low = hit(bus_in, ADDR_ALT_LOW, 1'b0);
    wire wr_cmpv_high = hit(bus_in, ADDR_CMPV_HIGH, 1'b1);
    wire wr_cmpv_low = hit(bus_in, ADDR_CMPV_LOW, 1'b1);
    wire acc_cmpv_low = wr_cmpv_low | hit(bus_in, ADDR_CMPV_LOW, 1'b0);
    wire wr_control = hit(bus_in, ADDR_CONTROL, 1'b1);
    wire comparator_en = cmp_enables[BIT_COMPARATOR_EN];

    wire tick = running & (prescale == PRESCALE_LAST);
    wire rollover = tick & (count == 16'hFFFF);
    wire match_now = tick & compare_on & (count == compare_value);
    wire take_capture = capture_edge & ~capture_blocked;

    // conditioned capture input
    wire conditioned = comparator_en ? comparator_result_in : capture_input_pin_in;

    capture_sync u_sync (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .level_in(conditioned),
        .rising_in(edge_polarity),
        .level_out(capture_level),
        .edge_out(capture_edge)
    );

    // counter, prescaler and start-up delay
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            count <= COUNT_PRESET;
            prescale <= 2'h0;
            startup <= 16'h0000;
            running <= 1'b0;
        end else begin
            if (!running) begin
                startup <= startup + 16'h0001;
                running <= (startup == START_LAST);
            end
            if (running)
                prescale <= prescale + 2'h1;
            if (tick)
                count <= count + 16'h0001;
        end
    end

    // low-byte latches for both counter read pairs
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            alt_frozen <= 1'b0;
            prim_frozen <= 1'b0;
            alt_low_hold <= 8'h00;
            prim_low_hold <= 8'h00;
        end else begin
            if (rd_alt_high && !alt_frozen) begin
                alt_low_hold <= count[7:0];
                alt_frozen <= 1'b1;
            end else if (rd_alt_low) begin
                alt_frozen <= 1'b0;
            end
            if (rd_prim_high && !prim_frozen) begin
                prim_low_hold <= count[7:0];
                prim_frozen <= 1'b1;
            end else if (rd_prim_low) begin
                prim_frozen <= 1'b0;
            end
        end
    end

    // control bits with reset
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            port_c_dir <= PORT_C_DIR_RESET;
            cmp_enables <= CMP_ENABLES_RESET;
            irq_enables <= 3'h0;
        end else begin
            if (hit(bus_in, ADDR_PORT_C_DIR, 1'b1))
                port_c_dir <= bus_in.wdata;
            if (hit(bus_in, ADDR_CMP_ENABLES, 1'b1))
                cmp_enables <= bus_in.wdata;
            if (wr_control)
                irq_enables <= bus_in.wdata[BIT_CAPT_IRQ_EN:BIT_ROLL_IRQ_EN];
        end
    end

    // state kept through reset
    always_ff @(posedge clock_in) begin
        if (wr_control)
            edge_polarity <= bus_in.wdata[BIT_EDGE_POL];
        if (wr_cmpv_high)
            compare_value[15:8] <= bus_in.wdata;
        if (wr_cmpv_low)
            compare_value[7:0] <= bus_in.wdata;
        if (take_capture)
            captured <= count + 16'h0001;
        if (take_capture)
            capture_flag <= 1'b1;
        else if (rd_capt_low && capture_armed)
            capture_flag <= 1'b0;
        if (match_now)
            match_flag <= 1'b1;
        else if (acc_cmpv_low && match_armed)
            match_flag <= 1'b0;
        if (rollover)
            rollover_flag <= 1'b1;
        else if (rd_prim_low && rollover_armed)
            rollover_flag <= 1'b0;
    end

    // clear arming, compare and capture inhibits
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            capture_armed <= 1'b0;
            match_armed <= 1'b0;
            rollover_armed <= 1'b0;
            capture_blocked <= 1'b0;
            compare_on <= 1'b1;
        end else begin
            if (rd_flags)
                capture_armed <= capture_flag;
            else if (rd_capt_low)
                capture_armed <= 1'b0;
            if (rd_flags)
                match_armed <= match_flag;
            else if (acc_cmpv_low)
                match_armed <= 1'b0;
            if (rd_flags)
                rollover_armed <= rollover_flag;
            else if (rd_prim_low)
                rollover_armed <= 1'b0;
            if (rd_capt_high)
                capture_blocked <= 1'b1;
            else if (rd_capt_low)
                capture_blocked <= 1'b0;
            if (wr_cmpv_high)
                compare_on <= 1'b0;
            else if (wr_cmpv_low)
                compare_on <= 1'b1;
        end
    end

    // read mux; alternate pair has no write path
    logic [7:0] next_read;
    always_comb begin
        next_read = 8'h00;
        case (bus_in.addr)
            ADDR_PORT_C_DIR: next_read = port_c_dir;
            ADDR_CMP_ENABLES: next_read = cmp_enables;
            ADDR_CONTROL: next_read = {irq_enables, 3'h0, edge_polarity, 1'b0};
            ADDR_FLAGS: next_read = {capture_flag, match_flag, rollover_flag, 5'h00};
            ADDR_CAPT_HIGH: next_read = captured[15:8];
            ADDR_CAPT_LOW: next_read = captured[7:0];
            ADDR_CMPV_HIGH: next_read = compare_value[15:8];
            ADDR_CMPV_LOW: next_read = compare_value[7:0];
            ADDR_PRIM_HIGH: next_read = count[15:8];
            ADDR_PRIM_LOW: next_read = prim_frozen ? prim_low_hold : count[7:0];
            ADDR_ALT_HIGH: next_read = count[15:8];
            ADDR_ALT_LOW: next_read = alt_frozen ? alt_low_hold : count[7:0];
            default: next_read = 8'h00;
        endcase
    end

    // pin and irq next values
    wire next_irq = (capture_flag & irq_enables[2]) | (match_flag & irq_enables[1])
        | (rollover_flag & irq_enables[0]);
    wire match_pin_en = port_c_dir[BIT_MATCH_PIN_EN];
    wire next_pc_out = match_pin_en ? match_flag : port_c_bit0_data_in;
    wire next_pc_oe = match_pin_en | port_c_dir[0];
    wire next_pb_oe = port_b_bit0_dir_in & ~comparator_en;
    wire next_pb_read = comparator_en ? capture_level : port_b_bit0_data_in;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            read_data_out <= 8'h00;
            timer_irq_out <= 1'b0;
            match_output_pin_out <= 1'b0;
            match_output_pin_oe_out <= 1'b0;
            port_b_bit0_oe_out <= 1'b0;
            port_b_bit0_read_out <= 1'b0;
            comparator_power_out <= 1'b0;
        end else begin
            read_data_out <= bus_in.rd ? next_read : 8'h00;
            timer_irq_out <= next_irq;
            match_output_pin_out <= next_pc_out;
            match_output_pin_oe_out <= next_pc_oe;
            port_b_bit0_oe_out <= next_pb_oe;
            port_b_bit0_read_out <= next_pb_read;
            comparator_power_out <= comparator_en;
        end
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);

    a_count_preset: assert property (@(posedge clock_in) disable iff (1'b0)
        reset_in |=> count == COUNT_PRESET)
        else $error("counter not preset after reset");
    a_count_step: assert property (tick |=> count == $past(count) + 16'h0001)
        else $error("counter did not advance on tick");
    a_count_quiet: assert property (!tick |=> $stable(count))
        else $error("counter moved off tick");
    a_alt_freeze: assert property (rd_alt_high && !alt_frozen ##1 !rd_alt_low
        |=> alt_low_hold == $past(count[7:0], 2) && alt_frozen)
        else $error("alternate low byte not frozen");
    a_capture_load: assert property (take_capture |=> captured == $past(count) + 16'h0001
        && capture_flag)
        else $error("capture value wrong");
    a_capture_block: assert property (capture_blocked && !rd_capt_low |=> $stable(captured))
        else $error("capture taken while blocked");
    a_match_set: assert property (match_now |=> match_flag ##1 match_output_pin_out
        || !$past(match_pin_en))
        else $error("match flag not set");
    a_compare_hold: assert property (wr_cmpv_high |=> !compare_on)
        else $error("compare not suspended");
    a_pin_input: assert property (comparator_en |=> !port_b_bit0_oe_out)
        else $error("shared pin driven with comparator on");
    a_irq_gate: assert property (!irq_enables[1] && !irq_enables[2] && !irq_enables[0]
        |=> !timer_irq_out)
        else $error("irq without enable");

    // start-up, prescaler, flag, pin and irq checks
    a_startup_hold: assert property (!running |-> count == COUNT_PRESET)
        else $error("counter moved during start-up delay");
    a_prescale_tick: assert property (tick |=> !tick ##1 !tick ##1 !tick)
        else $error("prescaler tick spacing wrong");
    a_alt_keep_flag: assert property ((rd_alt_high || rd_alt_low) && rollover_flag
        |=> rollover_flag)
        else $error("alternate read cleared rollover flag");
    a_capt_clear: assert property (rd_capt_low && capture_armed && !take_capture
        |=> !capture_flag)
        else $error("armed capture low read did not clear flag");
    a_match_clear: assert property (acc_cmpv_low && match_armed && !match_now
        |=> !match_flag)
        else $error("armed compare low access did not clear flag");
    a_arm_only_set: assert property (rd_flags && !capture_flag |=> !capture_armed)
        else $error("capture flag armed while clear");
    a_pin_follow: assert property (match_pin_en
        |=> match_output_pin_out == $past(match_flag) && match_output_pin_oe_out)
        else $error("match pin does not follow flag");
    a_port_read: assert property (comparator_en
        |=> port_b_bit0_read_out == $past(capture_level))
        else $error("port read does not show capture pin");
    a_pb_follow: assert property (!comparator_en
        |=> port_b_bit0_oe_out == $past(port_b_bit0_dir_in))
        else $error("shared pin enable does not follow direction");
    a_irq_match: assert property (match_flag && irq_enables[1] |=> timer_irq_out)
        else $error("enabled match gave no irq");
    a_flags_readonly: assert property (bus_in.wr && bus_in.addr == ADDR_FLAGS
        && !take_capture && !match_now && !rollover
        |=> $stable({capture_flag, match_flag, rollover_flag}))
        else $error("flag register changed on write");
endmodule // timer_capture_compare_unit

// *** test/capture_source.sv ***
// capture signal source that moves its pin away from the clock edge
`timescale 1ns/1ps
module capture_source (
    // clock
    input wire logic clock_in,
    // requested level
    input wire logic target_in,
    // pin towards the device
    output logic pin_out
);
    initial pin_out = 1'b0;
    // lag keeps transitions asynchronous to the sampling edge
    always @(posedge clock_in) begin
        pin_out <= #2.3 target_in;
    end
endmodule // capture_source

// *** test/timer_capture_compare_unit_tb_top.sv ***
// self-checking bench for the timer capture/compare unit
`timescale 1ns/1ps
module timer_capture_compare_unit_tb_top;
    import timer_cc_pkg::*;
    localparam int START = 40;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    bus_req_t bus = '0;
    logic [7:0] rdata;
    logic [7:0] f;
    logic [7:0] fk;
    logic pin_t = 1'b0;
    logic cmp_t = 1'b0;
    logic pin, cmp, pb_oe, pb_rd, pwr, mpin, mpin_oe, irq;
    logic pb_data = 1'b0;
    logic pb_dir = 1'b0;
    logic pc_data = 1'b0;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int rc, c0, pol, i;
    logic [31:0] seed = 32'h000007E1;
    logic [15:0] a, b, t, capt;

    always #2.5 clock_in = ~clock_in;
    always @(posedge clock_in) cyc++;

    capture_source pin_src (.clock_in(clock_in), .target_in(pin_t), .pin_out(pin));
    capture_source cmp_src (.clock_in(clock_in), .target_in(cmp_t), .pin_out(cmp));
    timer_capture_compare_unit #(.STARTUP_COUNT(START)) uut (
        .clock_in(clock_in), .reset_in(reset_in), .bus_in(bus), .read_data_out(rdata),
        .capture_input_pin_in(pin), .comparator_result_in(cmp),
        .port_b_bit0_data_in(pb_data), .port_b_bit0_dir_in(pb_dir),
        .port_b_bit0_oe_out(pb_oe), .port_b_bit0_read_out(pb_rd),
        .comparator_power_out(pwr), .port_c_bit0_data_in(pc_data),
        .match_output_pin_out(mpin), .match_output_pin_oe_out(mpin_oe),
        .timer_irq_out(irq)
    );

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // counter ticks over a span of bus cycles, for either prescaler phase
    function automatic logic ticks_ok(input logic [15:0] d, input int span);
        return (d == 16'(span / 4)) || (d == 16'((span + 3) / 4));
    endfunction
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clock_in);
        bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_in);
        bus <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        @(posedge clock_in);
        bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock_in);
        bus <= '0;
        #1;
        d = rdata;
        rc = cyc;
    endtask
    // high byte first, then the low byte that ends the sequence
    task automatic rd_pair(input logic [7:0] hi, output logic [15:0] v);
        rd(hi, v[15:8]);
        rd(hi + 8'h01, v[7:0]);
    endtask
    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #25000;
        n_errors++;
        final_report();
    end

    initial begin
        settle(10);
        reset_in <= 1'b0;
        rd_pair(ADDR_ALT_HIGH, a);
        check("count_after_reset", a, COUNT_PRESET);
        settle(20);
        rd_pair(ADDR_ALT_HIGH, a);
        check("count_in_startup", a, COUNT_PRESET);
        rd(ADDR_PORT_C_DIR, f);
        check("port_c_dir_reset", f, PORT_C_DIR_RESET);
        rd(ADDR_CMP_ENABLES, f);
        check("cmp_enables_reset", f, CMP_ENABLES_RESET);
        settle(40);
        rd_pair(ADDR_ALT_HIGH, a);
        c0 = rc;
        wr(ADDR_ALT_HIGH, 8'hFF);
        wr(ADDR_ALT_LOW, 8'h00);
        settle(380);
        rd_pair(ADDR_ALT_HIGH, b);
        check("count_rate", ticks_ok(b - a, rc - c0), 1'b1);
        rd(ADDR_ALT_HIGH, a[15:8]);
        c0 = rc;
        for (i = 0; i < 3; i++) begin
            settle(10);
            rd(ADDR_ALT_HIGH, f);
        end
        rd(ADDR_ALT_LOW, a[7:0]);
        rd(ADDR_ALT_HIGH, b[15:8]);
        c0 = rc - c0;
        rd(ADDR_ALT_LOW, b[7:0]);
        check("low_frozen", ticks_ok(b - a, c0), 1'b1);
        rd(ADDR_FLAGS, f);
        rd(ADDR_ALT_LOW, f);
        wr(ADDR_FLAGS, 8'h00);
        rd(ADDR_FLAGS, f);
        check("flags_after_alt", f[5:0], 6'h20);
        for (i = 0; i < 8; i++) begin
            seed = xorshift(seed);
            pb_data <= seed[0];
            pb_dir <= seed[1];
            pc_data <= seed[2];
            settle(3);
            check("pb_oe", pb_oe, pb_dir);
            check("pc_out", mpin, pc_data);
            check("pc_oe", mpin_oe, 1'b0);
        end
        wr(ADDR_CMP_ENABLES, 8'h80);
        pb_dir <= 1'b1;
        pb_data <= 1'b0;
        pin_t <= 1'b1;
        cmp_t <= 1'b1;
        settle(6);
        check("comparator_power", pwr, 1'b1);
        check("pb_oe_forced", pb_oe, 1'b0);
        check("pb_read_pin", pb_rd, 1'b1);
        wr(ADDR_CMP_ENABLES, 8'h00);
        wr(ADDR_CONTROL, 8'h00);
        rd_pair(ADDR_ALT_HIGH, a);
        seed = xorshift(seed);
        t = a + 16'h000C + 16'(seed[3:0]);
        rd(ADDR_FLAGS, f);
        wr(ADDR_CMPV_HIGH, t[15:8]);
        wr(ADDR_CMPV_LOW, t[7:0]);
        rd(ADDR_FLAGS, f);
        check("match_clear_by_write", f[6], 1'b0);
        for (i = 0; i < 100 && f[6] !== 1'b1; i++) begin
            rd(ADDR_FLAGS, f);
        end
        rd_pair(ADDR_ALT_HIGH, b);
        check("match_flag", f[6], 1'b1);
        check("match_time", (b - t) inside {[16'h0001:16'h0003]}, 1'b1);
        wr(ADDR_PORT_C_DIR, 8'h80);
        wr(ADDR_CONTROL, 8'h40);
        settle(2);
        check("match_pin", {mpin, mpin_oe}, 2'b11);
        check("match_irq", irq, 1'b1);
        wr(ADDR_CONTROL, 8'h00);
        settle(2);
        check("match_irq_masked", irq, 1'b0);
        rd(ADDR_FLAGS, f);
        rd(ADDR_CMPV_LOW, f);
        check("cmp_low_rw", f, t[7:0]);
        rd(ADDR_FLAGS, f);
        check("match_clear_by_read", f[6], 1'b0);
        settle(2);
        check("match_pin_low", mpin, 1'b0);
        rd_pair(ADDR_ALT_HIGH, a);
        t = a + 16'h000C;
        wr(ADDR_CMPV_LOW, t[7:0]);
        wr(ADDR_CMPV_HIGH, t[15:8]);
        settle(100);
        rd(ADDR_FLAGS, f);
        check("compare_suspended", f[6], 1'b0);
        wr(ADDR_CMPV_LOW, t[7:0]);
        for (pol = 1; pol >= 0; pol--) begin
            wr(ADDR_CONTROL, pol[0] ? 8'h02 : 8'h00);
            pin_t <= pol[0];
            settle(8);
            rd(ADDR_FLAGS, f);
            rd(ADDR_CAPT_LOW, f);
            pin_t <= !pol[0];
            settle(8);
            rd(ADDR_FLAGS, f);
            check("wrong_edge", f[7], 1'b0);
            rd_pair(ADDR_ALT_HIGH, a);
            pin_t <= pol[0];
            settle(8);
            rd(ADDR_FLAGS, f);
            check("right_edge", f[7], 1'b1);
            rd_pair(ADDR_CAPT_HIGH, capt);
            check("capture_plus_one", (capt - a) inside {[16'h0001:16'h0003]}, 1'b1);
            rd(ADDR_FLAGS, f);
            check("capture_cleared", f[7], 1'b0);
        end
        rd(ADDR_CAPT_HIGH, f);
        pin_t <= 1'b1;
        settle(8);
        pin_t <= 1'b0;
        settle(8);
        rd(ADDR_FLAGS, f);
        check("capture_blocked", f[7], 1'b0);
        rd(ADDR_CAPT_LOW, f);
        check("blocked_value", f, capt[7:0]);
        wr(ADDR_CONTROL, 8'h02);
        wr(ADDR_CMP_ENABLES, 8'h80);
        cmp_t <= 1'b0;
        settle(8);
        rd(ADDR_FLAGS, f);
        rd(ADDR_CAPT_LOW, f);
        pin_t <= 1'b1;
        settle(8);
        rd(ADDR_FLAGS, f);
        check("schmitt_ignored", f[7], 1'b0);
        cmp_t <= 1'b1;
        settle(8);
        rd(ADDR_FLAGS, fk);
        check("comparator_capture", fk[7], 1'b1);
        rd_pair(ADDR_CAPT_HIGH, capt);
        rd(ADDR_FLAGS, fk);
        reset_in <= 1'b1;
        settle(10);
        reset_in <= 1'b0;
        rd(ADDR_FLAGS, f);
        check("flags_kept", f, fk);
        rd_pair(ADDR_ALT_HIGH, a);
        check("count_rereset", a, COUNT_PRESET);
        rd_pair(ADDR_CAPT_HIGH, b);
        check("capture_kept", b, capt);
        rd_pair(ADDR_CMPV_HIGH, b);
        check("compare_kept", b, t);
        rd(ADDR_CONTROL, f);
        check("polarity_kept", f, 8'h02);
        rd(ADDR_CMP_ENABLES, f);
        check("cmp_enables_cleared", f, CMP_ENABLES_RESET);
        final_report();
    end
endmodule // timer_capture_compare_unit_tb_top
